// *** bench/dual_prescaled_down_counters_properties.sv ***
// watches the counter block at its ports only
module dual_prescaled_down_counters_properties (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       external_count_input_pin,
	input wire logic       counter_halt_input_n,
	input wire logic       serial_mode_enable,
	input wire logic       count_output_pin,
	input wire logic       first_count_done_request,
	input wire logic       second_count_done_request,
	input wire logic       bit_rate_tick
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// a request can only follow a cycle in which the halt line was high
	a_first_halt: assert property (
		first_count_done_request |-> $past(counter_halt_input_n))
		else $error("first request after a halted cycle");
	a_second_halt: assert property (
		second_count_done_request |-> $past(counter_halt_input_n))
		else $error("second request after a halted cycle");
	// ticks come every four cycles, so first requests are never closer than that
	a_first_spacing: assert property (
		first_count_done_request |=> !first_count_done_request [*3])
		else $error("first requests closer than four cycles");
	// the bit-rate pulse is the first end pulse, only in serial mode
	a_bitrate_source: assert property (
		bit_rate_tick |-> first_count_done_request)
		else $error("bit-rate pulse without first request");
	a_bitrate_follow: assert property (
		first_count_done_request && serial_mode_enable && $past(serial_mode_enable)
		|-> bit_rate_tick)
		else $error("bit-rate pulse missing in serial mode");
	a_bitrate_off: assert property (
		!$past(serial_mode_enable) |-> !bit_rate_tick)
		else $error("bit-rate pulse outside serial mode");

	////////////////////////////////////////////////////////////////////////////////
	// read data only moves when a read was taken
	a_rdata_hold: assert property (
		!$past(reg_rd_en) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_prescaler_hidden: assert property (
		$past(reg_rd_en) && ($past(reg_addr) == timer_pkg::FIRST_PRESCALER_SETUP_ADDR
		|| $past(reg_addr) == timer_pkg::SECOND_PRESCALER_SETUP_ADDR)
		|-> reg_rdata == 8'h00)
		else $error("prescaler setup was readable");
	a_load_bits_zero: assert property (
		$past(reg_rd_en) && $past(reg_addr) == timer_pkg::TIMER_MODE_CONTROL_ADDR
		|-> !reg_rdata[0] && !reg_rdata[2])
		else $error("load bits read back as set");
	a_unmapped_zero: assert property (
		$past(reg_rd_en) && ($past(reg_addr) < 8'hF1 || $past(reg_addr) > 8'hF5)
		|-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind dual_prescaled_down_counters dual_prescaled_down_counters_properties i_props (
	.core_clk, .reset_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
	.external_count_input_pin, .counter_halt_input_n, .serial_mode_enable,
	.count_output_pin, .first_count_done_request, .second_count_done_request,
	.bit_rate_tick
);

// *** bench/dual_prescaled_down_counters_tb.sv ***
module dual_prescaled_down_counters_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       core_clk;
	logic       reset_n;
	logic [7:0] reg_addr;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       ext_pin;
	logic       halt_n;
	logic       serial_mode_enable;
	logic       out_pin;
	logic       req_first;
	logic       req_second;
	int         failures;
	int         n_compared;
	int         n_req [2];  // requests seen per counter
	int         n_toggle;   // output pin changes
	logic       out_last;

	dual_prescaled_down_counters i_dut (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .external_count_input_pin(ext_pin),
		.counter_halt_input_n(halt_n), .serial_mode_enable(serial_mode_enable),
		.count_output_pin(out_pin), .first_count_done_request(req_first),
		.second_count_done_request(req_second), .bit_rate_tick()
	);
	ext_signal_source i_src (.core_clk(core_clk), .ext_pin(ext_pin), .halt_n(halt_n));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// event counters sampled at each edge
	always @(posedge core_clk) begin
		out_last <= out_pin;
		if (req_first === 1'b1)
			n_req[0] <= n_req[0] + 1;
		if (req_second === 1'b1)
			n_req[1] <= n_req[1] + 1;
		if (out_pin !== out_last)
			n_toggle <= n_toggle + 1;
	end

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkn(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// register port: one-cycle strobes launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr_en = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd_en = 1'b0;
		d = reg_rdata;
	endtask

	// waits, bounded, until a counter's requests differ from base
	task automatic wait_req(input int w, input int base, input int bound, output int cyc);
		cyc = 0;
		while (n_req[w] == base) begin
			if (cyc >= bound) begin
				failures++;
				$display("[ERR] request wait expected <= %0d seen more", bound);
				report_and_stop();
			end
			@(posedge core_clk);
			#1;
			cyc++;
		end
	endtask

	// cycles between two successive requests
	task automatic period(input int w, input int bound, output int cyc);
		wait_req(w, n_req[w], bound, cyc);
		wait_req(w, n_req[w], bound, cyc);
	endtask

	// no request for a number of cycles
	task automatic quiet(input int w, input int cyc);
		int base;
		base = n_req[w];
		repeat (cyc) @(posedge core_clk);
		#1;
		chkn("silent counter", base, n_req[w]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		logic [7:0] d;
		for (int a = 'hF0; a <= 'hF6; a++) begin
			rd(8'(a), d);
			chk8("reset read", 8'h00, d);
		end
		$display("test reset_values done");
	endtask

	// first counter periods and output pin choices
	task automatic t_first;
		int cyc;
		int t0;
		wr(8'hF5, 8'h05);
		wr(8'hF4, 8'h02);
		wr(8'hF1, 8'h43);
		period(0, 40, cyc);
		chkn("first period", 8, cyc);
		t0 = n_toggle;
		period(0, 40, cyc);
		chkn("first pin toggles", 2, n_toggle - t0);
		wr(8'hF5, 8'h01);
		wr(8'hF4, 8'h01);
		wr(8'hF1, 8'h03);
		period(0, 600, cyc);
		chkn("divide by 64 period", 256, cyc);
		wr(8'hF5, 8'h05);
		wr(8'hF4, 8'h00);
		wr(8'hF1, 8'h03);
		period(0, 2200, cyc);
		chkn("zero load period", 1024, cyc);
		wr(8'hF1, 8'hC0);
		repeat (2) @(posedge core_clk);
		#1;
		t0 = n_toggle;
		repeat (32) @(posedge core_clk);
		#1;
		chkn("clock pin toggles", 8, n_toggle - t0);
		wr(8'hF1, 8'h00);
		repeat (2) @(posedge core_clk);
		#1;
		t0 = n_toggle;
		repeat (8) @(posedge core_clk);
		#1;
		chkn("off pin toggles", 0, n_toggle - t0);
		chk8("off pin level", 8'h00, {7'h00, out_pin});
		$display("test first done");
	endtask

	task automatic t_single_pass;
		int cyc;
		logic [7:0] d;
		serial_mode_enable = 1'b0;
		wr(8'hF5, 8'h04);
		wr(8'hF4, 8'h03);
		wr(8'hF1, 8'h03);
		wait_req(0, n_req[0], 60, cyc);
		quiet(0, 80);
		rd(8'hF4, d);
		chk8("single pass end", 8'h00, d);
		rd(8'hF1, d);
		chk8("mode readback", 8'h02, d);
		serial_mode_enable = 1'b1;
		$display("test single_pass done");
	endtask

	// stop, continue from current count, halt line freeze
	task automatic t_stop_halt;
		int cyc;
		logic [7:0] v1;
		logic [7:0] v2;
		wr(8'hF5, 8'h05);
		wr(8'hF4, 8'h10);
		wr(8'hF1, 8'h03);
		period(0, 100, cyc);
		chkn("sixteen period", 64, cyc);
		repeat (40) @(posedge core_clk);
		wr(8'hF1, 8'h00);
		rd(8'hF4, v1);
		quiet(0, 40);
		rd(8'hF4, v2);
		chk8("stopped count", v1, v2);
		wr(8'hF1, 8'h02);
		wait_req(0, n_req[0], 4 * int'(v1) + 8, cyc);
		i_src.set_halt(1'b0);
		rd(8'hF4, v1);
		quiet(0, 40);
		rd(8'hF4, v2);
		chk8("halted count", v1, v2);
		i_src.set_halt(1'b1);
		period(0, 100, cyc);
		chkn("period after halt", 64, cyc);
		$display("test stop_halt done");
	endtask

	// second counter from internal clock/4, then cascaded from the first
	task automatic t_second;
		int cyc;
		int t0;
		wr(8'hF3, 8'h0B);
		wr(8'hF2, 8'h03);
		wr(8'hF1, 8'h8C);
		period(1, 100, cyc);
		chkn("second period", 24, cyc);
		t0 = n_toggle;
		period(1, 100, cyc);
		chkn("second pin toggles", 2, n_toggle - t0);
		wr(8'hF5, 8'h07);
		wr(8'hF4, 8'h02);
		wr(8'hF3, 8'h07);
		wr(8'hF2, 8'h02);
		wr(8'hF1, 8'h0F);
		period(1, 100, cyc);
		chkn("cascade period", 16, cyc);
		$display("test second done");
	endtask

	// each external pin function: idle is silent, activity requests
	task automatic t_ext_modes;
		int cyc;
		int base;
		wr(8'hF5, 8'h05); // cascade off
		for (int m = 0; m < 4; m++) begin
			wr(8'hF3, 8'h04);
			wr(8'hF2, 8'h02);
			wr(8'hF1, 8'(m << 4) | 8'h0C);
			quiet(1, 30);
			base = n_req[1];
			if (m == 1)
				i_src.pulses(1, 16, 2);
			else
				i_src.pulses(5, 2, 2);
			if (m == 3)
				chkn("retrigger holdoff", base, n_req[1]);
			wait_req(1, base, 40, cyc);
		end
		$display("test ext_modes done");
	endtask

	initial begin
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
		serial_mode_enable = 1'b1;
		failures = 0;
		n_compared = 0;
		n_req = '{0, 0};
		n_toggle = 0;
		out_last = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		t_reset_values();
		t_first();
		t_single_pass();
		t_stop_halt();
		t_second();
		t_ext_modes();
		report_and_stop();
	end

	// hang guard
	initial begin
		#500000;
		failures++;
		$display("[ERR] run length expected done seen timeout");
		report_and_stop();
	end
endmodule

// *** bench/ext_signal_source.sv ***
// far side: drives the external count pin and the halt line
module ext_signal_source (
	input  wire logic core_clk,
	output logic      ext_pin,
	output logic      halt_n
);
	timeunit 1ns;
	timeprecision 100ps;

	// pin rests low between bursts; halt rests high as its pull-up would hold it
	initial begin
		ext_pin = 1'b0;
		halt_n  = 1'b1;
	end

	// n rising edges, high for hi cycles and low for lo cycles each
	task automatic pulses(input int n, input int hi, input int lo);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			ext_pin = 1'b1;
			repeat (hi) @(posedge core_clk);
			#1;
			ext_pin = 1'b0;
			repeat (lo - 1) @(posedge core_clk);
		end
	endtask

	// halt line level, changed just after an edge
	task automatic set_halt(input logic lvl);
		@(posedge core_clk);
		#1;
		halt_n = lvl;
	endtask
endmodule

// *** rtl/down_counter.sv ***
// down-counter with single-pass and continuous reload
module down_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             load,
	input  wire logic             step,
	input  wire logic             continuous,
	input  wire logic [WIDTH-1:0] initial_value,
	output logic [WIDTH-1:0]      value,
	output logic                  stopped,
	output logic                  done
);

	initial begin
		if (WIDTH < 2 || WIDTH > 16) $error("down_counter: WIDTH out of range");
	end

	logic [WIDTH-1:0] next_value;
	logic             next_stopped;

	////////////////////////////////////////////////////////////////////////////////////////////
	// next count; done marks the step from one to the end
	always_comb begin
		next_value   = value;
		next_stopped = stopped;
		done         = 1'b0;
		if (load) begin
			// restart from the initial value; zero runs 256 steps
			next_value   = initial_value;
			next_stopped = 1'b0;
		end else if (step && !stopped) begin
			if (value == WIDTH'(1)) begin
				done = 1'b1;
				if (continuous) begin
					next_value = initial_value;
				end else begin
					next_value   = '0;
					next_stopped = 1'b1;
				end
			end else begin
				next_value = value - WIDTH'(1);
			end
		end
	end

	// value and halt flag; idle until first load
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			value   <= '0;
			stopped <= 1'b1;
		end else begin
			value   <= next_value;
			stopped <= next_stopped;
		end
	end

endmodule

// *** rtl/dual_prescaled_down_counters.sv ***
// two prescaled down-counters behind the core register port
module dual_prescaled_down_counters #(
	parameter int COUNT_WIDTH   = 8,
	parameter int PRESCALE_WIDTH = 6
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,                   // register file address
	input  wire logic       reg_wr_en,                  // write strobe
	input  wire logic       reg_rd_en,                  // read strobe
	input  wire logic [7:0] reg_wdata,                  // write data
	output logic      [7:0] reg_rdata,                  // read data, held
	input  wire logic       external_count_input_pin,   // external clock/trigger/gate
	input  wire logic       counter_halt_input_n,       // low stops both counters and prescalers
	input  wire logic       serial_mode_enable,         // serial unit in use
	output logic            count_output_pin,           // selected timer output
	output logic            first_count_done_request,   // first end-of-count pulse
	output logic            second_count_done_request,  // second end-of-count pulse
	output logic            bit_rate_tick               // serial bit-rate pulse
);

	initial begin
		if (COUNT_WIDTH != 8 || PRESCALE_WIDTH != 6) begin
			$error("dual_prescaled_down_counters: register widths are fixed at 8 and 6");
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [7:0] mode_ctl;               // run, external mode and output select
	logic [7:0] first_init;             // first initial value
	logic [7:0] second_init;            // second initial value
	logic [7:0] first_setup;            // first prescaler setup
	logic [7:0] second_setup;           // second prescaler setup

	// counting state
	logic [1:0] div_count;              // internal clock/4 divider
	logic       ext_prev;               // external pin last cycle
	logic       triggered;              // second counter trigger seen
	logic       first_toggle;           // first counter output level
	logic       second_toggle;          // second counter output level
	logic       internal_toggle;        // internal clock output level

	// next values
	logic [7:0] next_mode_ctl;
	logic [7:0] next_first_init;
	logic [7:0] next_second_init;
	logic [7:0] next_first_setup;
	logic [7:0] next_second_setup;
	logic [1:0] next_div_count;
	logic       next_triggered;
	logic       next_first_toggle;
	logic       next_second_toggle;
	logic       next_internal_toggle;

	// next outputs
	logic [7:0] next_reg_rdata;
	logic       next_count_output_pin;
	logic       next_bit_rate_tick;

	// strobes
	logic       tick_internal;          // one cycle in four
	logic       ext_rise;               // external pin rising edge
	logic       run_ok;                 // halt input released
	logic       load_first;             // first restart from initial
	logic       load_second;            // second restart from initial
	logic       trigger_load;           // trigger restarts second
	logic       first_pre_step;
	logic       second_pre_step;
	logic       second_source;          // selected second source pulse

	// channel outputs
	logic       first_pre_end;
	logic       second_pre_end;
	logic [7:0] first_value;
	logic [7:0] second_value;
	logic       first_stopped;
	logic       second_stopped;
	logic       first_done;
	logic       second_done;

	// mode fields
	timer_pkg::ext_mode_t   ext_mode;
	timer_pkg::out_select_t out_sel;

	////////////////////////////////////////////////////////////////////////////////////////////
	// decode of control fields
	always_comb begin
		ext_mode      = timer_pkg::ext_mode_t'(mode_ctl[timer_pkg::MODE_EXT_LSB +: 2]);
		out_sel       = timer_pkg::out_select_t'(mode_ctl[timer_pkg::MODE_OUT_LSB +: 2]);
		tick_internal = (div_count == 2'(timer_pkg::INTERNAL_CLOCK_DIVIDE - 1));
		ext_rise      = external_count_input_pin && !ext_prev;
		run_ok        = counter_halt_input_n;
		// load strobes
		load_first    = reg_wr_en && reg_addr == timer_pkg::TIMER_MODE_CONTROL_ADDR
			&& reg_wdata[timer_pkg::MODE_LOAD_FIRST_BIT];
		load_second   = reg_wr_en && reg_addr == timer_pkg::TIMER_MODE_CONTROL_ADDR
			&& reg_wdata[timer_pkg::MODE_LOAD_SECOND_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// second counter source selection
	always_comb begin
		trigger_load = 1'b0;
		if (second_setup[timer_pkg::PRE_SOURCE_BIT]) begin
			second_source = tick_internal;
		end else begin
			case (ext_mode)
				timer_pkg::EXT_CLOCK: begin
					second_source = ext_rise;
				end
				timer_pkg::EXT_GATE: begin
					second_source = tick_internal && external_count_input_pin;
				end
				timer_pkg::EXT_TRIGGER_ONCE: begin
					second_source = tick_internal && triggered;
					trigger_load  = ext_rise && (!triggered || second_stopped);
				end
				timer_pkg::EXT_TRIGGER_RE: begin
					second_source = tick_internal && triggered;
					trigger_load  = ext_rise;
				end
				default: begin
					second_source = 1'b0;
				end
			endcase
		end

		// cascade wins
		if (first_setup[timer_pkg::PRE_CASCADE_BIT]) begin
			second_source = first_done;
		end
	end

	// prescaler steps: gated by run enable, halt input and counter state
	always_comb begin
		first_pre_step  = tick_internal && run_ok && !first_stopped
			&& mode_ctl[timer_pkg::MODE_RUN_FIRST_BIT];
		// second channel
		second_pre_step = second_source && run_ok && !second_stopped
			&& mode_ctl[timer_pkg::MODE_RUN_SECOND_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// counter channels
	// first channel
	prescale_divider #(.WIDTH(PRESCALE_WIDTH)) first_prescaler (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.load      (load_first),
		.step      (first_pre_step),
		.divisor   (first_setup[timer_pkg::PRE_DIVISOR_LSB +: PRESCALE_WIDTH]),
		.end_pulse (first_pre_end)
	);

	down_counter #(.WIDTH(COUNT_WIDTH)) first_counter (
		.core_clk      (core_clk),
		.reset_n       (reset_n),
		.load          (load_first),
		.step          (first_pre_end),
		.continuous    (first_setup[timer_pkg::PRE_CONTINUOUS_BIT]),
		.initial_value (first_init),
		.value         (first_value),
		.stopped       (first_stopped),
		.done          (first_done)
	);

	// second channel
	prescale_divider #(.WIDTH(PRESCALE_WIDTH)) second_prescaler (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.load      (load_second || trigger_load),
		.step      (second_pre_step),
		.divisor   (second_setup[timer_pkg::PRE_DIVISOR_LSB +: PRESCALE_WIDTH]),
		.end_pulse (second_pre_end)
	);

	down_counter #(.WIDTH(COUNT_WIDTH)) second_counter (
		.core_clk      (core_clk),
		.reset_n       (reset_n),
		.load          (load_second || trigger_load),
		.step          (second_pre_end),
		.continuous    (second_setup[timer_pkg::PRE_CONTINUOUS_BIT]),
		.initial_value (second_init),
		.value         (second_value),
		.stopped       (second_stopped),
		.done          (second_done)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// register writes; load bits act once and are not stored
	always_comb begin
		next_mode_ctl     = mode_ctl;
		next_first_init   = first_init;
		next_second_init  = second_init;
		next_first_setup  = first_setup;
		next_second_setup = second_setup;
		if (reg_wr_en) begin
			case (reg_addr)
				timer_pkg::TIMER_MODE_CONTROL_ADDR: begin
					next_mode_ctl = reg_wdata;
					// strobes only
					next_mode_ctl[timer_pkg::MODE_LOAD_FIRST_BIT]  = 1'b0;
					next_mode_ctl[timer_pkg::MODE_LOAD_SECOND_BIT] = 1'b0;
				end
				timer_pkg::SECOND_COUNTER_VALUE_ADDR:   next_second_init  = reg_wdata;
				timer_pkg::SECOND_PRESCALER_SETUP_ADDR: next_second_setup = reg_wdata;
				timer_pkg::FIRST_COUNTER_VALUE_ADDR:    next_first_init   = reg_wdata;
				timer_pkg::FIRST_PRESCALER_SETUP_ADDR:  next_first_setup  = reg_wdata;
				default: begin
					next_mode_ctl = mode_ctl;
				end
			endcase
		end
	end

	// register reads: live counts, prescalers read as zero
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd_en) begin
			case (reg_addr)
				timer_pkg::TIMER_MODE_CONTROL_ADDR:   next_reg_rdata = mode_ctl;
				timer_pkg::SECOND_COUNTER_VALUE_ADDR: next_reg_rdata = second_value;
				timer_pkg::FIRST_COUNTER_VALUE_ADDR:  next_reg_rdata = first_value;
				// read as zero
				default:                              next_reg_rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// divider, trigger flag, output levels
	always_comb begin
		next_div_count       = div_count + 2'h1;
		next_first_toggle    = first_toggle ^ first_done;
		next_second_toggle   = second_toggle ^ second_done;
		next_internal_toggle = internal_toggle ^ tick_internal;

		// set wins over clear
		next_triggered       = triggered;
		if (load_second || (second_done && !second_setup[timer_pkg::PRE_CONTINUOUS_BIT])) begin
			next_triggered = 1'b0;
		end
		if (trigger_load) begin
			next_triggered = 1'b1;
		end
		// pin select
		case (out_sel)
			timer_pkg::OUT_FIRST:    next_count_output_pin = next_first_toggle;
			timer_pkg::OUT_SECOND:   next_count_output_pin = next_second_toggle;
			timer_pkg::OUT_INTERNAL: next_count_output_pin = next_internal_toggle;
			default:                 next_count_output_pin = 1'b0;
		endcase
		// serial only
		next_bit_rate_tick = first_done && serial_mode_enable;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// state registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_ctl                  <= timer_pkg::MODE_RESET;
			first_init                <= timer_pkg::VALUE_RESET;
			second_init               <= timer_pkg::VALUE_RESET;
			first_setup               <= timer_pkg::SETUP_RESET;
			second_setup              <= timer_pkg::SETUP_RESET;
			// counting state
			div_count                 <= 2'h0;
			ext_prev                  <= 1'b0;
			triggered                 <= 1'b0;
			first_toggle              <= 1'b0;
			second_toggle             <= 1'b0;
			internal_toggle           <= 1'b0;
			// outputs
			reg_rdata                 <= 8'h00;
			count_output_pin          <= 1'b0;
			first_count_done_request  <= 1'b0;
			second_count_done_request <= 1'b0;
			bit_rate_tick             <= 1'b0;
		end else begin
			mode_ctl                  <= next_mode_ctl;
			first_init                <= next_first_init;
			second_init               <= next_second_init;
			first_setup               <= next_first_setup;
			second_setup              <= next_second_setup;
			// counting state
			div_count                 <= next_div_count;
			ext_prev                  <= external_count_input_pin;
			triggered                 <= next_triggered;
			first_toggle              <= next_first_toggle;
			second_toggle             <= next_second_toggle;
			internal_toggle           <= next_internal_toggle;
			// outputs
			reg_rdata                 <= next_reg_rdata;
			count_output_pin          <= next_count_output_pin;
			first_count_done_request  <= first_done;
			second_count_done_request <= second_done;
			bit_rate_tick             <= next_bit_rate_tick;
		end
	end

endmodule

// *** rtl/prescale_divider.sv ***
// programmable divider: one end pulse per divisor steps, divisor 0 means 2**WIDTH
module prescale_divider #(
	parameter int WIDTH = 6
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             load,
	input  wire logic             step,
	input  wire logic [WIDTH-1:0] divisor,
	output logic                  end_pulse
);

	initial begin
		if (WIDTH < 1 || WIDTH > 16) $error("prescale_divider: WIDTH out of range");
	end

	logic [WIDTH-1:0] count;        // remaining steps
	logic [WIDTH-1:0] next_count;

	////////////////////////////////////////////////////////////////////////////////////////////
	// next count: reload on load or at the last step, else decrement
	always_comb begin
		next_count = count;
		end_pulse  = 1'b0;
		if (load) begin
			next_count = divisor;
		end else if (step) begin
			if (count == WIDTH'(1)) begin
				// zero wraps through all codes, giving the full 64 division
				next_count = divisor;
				end_pulse  = 1'b1;
			end else begin
				next_count = count - WIDTH'(1);
			end
		end
	end

	// count register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule

// *** rtl/timer_pkg.sv ***
// What this block does
// - two 8-bit down-counters, each with 6-bit prescaler
// - first prescaler internal only; second selectable
// - prescalers divide by 1 through 64
// - counters count down loaded value 1..256
// - both at end raises that counter's request
// - start, stop, continue, or restart from initial
// - single-pass halts at zero; continuous reloads
// - counters readable without disturbance; prescalers not
// - second source: internal clock/4 or external pin
// - external input: clock, triggers, or gate
// - output pin carries first, second, or clock
// - cascade first counter output into second input
// - first counter sets serial bit rate
// - low halt input stops counters and prescalers
package timer_pkg;

	////////////////////////////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [7:0] TIMER_MODE_CONTROL_ADDR     = 8'hF1;
	localparam logic [7:0] SECOND_COUNTER_VALUE_ADDR   = 8'hF2;
	localparam logic [7:0] SECOND_PRESCALER_SETUP_ADDR = 8'hF3;
	localparam logic [7:0] FIRST_COUNTER_VALUE_ADDR    = 8'hF4;
	localparam logic [7:0] FIRST_PRESCALER_SETUP_ADDR  = 8'hF5;

	////////////////////////////////////////////////////////////////////////////////////////////
	// timer_mode_control fields
	localparam int MODE_LOAD_FIRST_BIT  = 0;   // write 1: restart first from initial
	localparam int MODE_RUN_FIRST_BIT   = 1;   // first counter enable
	localparam int MODE_LOAD_SECOND_BIT = 2;   // write 1: restart second from initial
	localparam int MODE_RUN_SECOND_BIT  = 3;   // second counter enable
	localparam int MODE_EXT_LSB         = 4;   // external input function, two bits
	localparam int MODE_OUT_LSB         = 6;   // output pin selection, two bits

	// prescaler setup fields
	localparam int PRE_CONTINUOUS_BIT   = 0;   // 1: continuous, 0: single pass
	localparam int PRE_SOURCE_BIT       = 1;   // second: 1 internal, 0 external pin
	localparam int PRE_CASCADE_BIT      = 1;   // first: 1 routes first output to second
	localparam int PRE_DIVISOR_LSB      = 2;   // six divisor bits, 0 means 64

	// reset values
	localparam logic [7:0] MODE_RESET  = 8'h00;
	localparam logic [7:0] VALUE_RESET = 8'h00;
	localparam logic [7:0] SETUP_RESET = 8'h00;

	// internal clock divide for the counting tick
	localparam int INTERNAL_CLOCK_DIVIDE = 4;

	////////////////////////////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [1:0] {
		EXT_CLOCK        = 2'b00,
		EXT_GATE         = 2'b01,
		EXT_TRIGGER_ONCE = 2'b10,
		EXT_TRIGGER_RE   = 2'b11
	} ext_mode_t;

	typedef enum logic [1:0] {
		OUT_OFF      = 2'b00,
		OUT_FIRST    = 2'b01,
		OUT_SECOND   = 2'b10,
		OUT_INTERNAL = 2'b11
	} out_select_t;

endpackage
